// ==== design/tsa_defines.svh ====
// Purpose: Constants of the temperature sensor alarm core
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef TSA_DEFINES_SVH
`define TSA_DEFINES_SVH

// ****************************************************************
// Register pointers
// ****************************************************************
`define TSA_PTR_TEMP        2'h0
`define TSA_PTR_CONFIG      2'h1
`define TSA_PTR_HYST        2'h2
`define TSA_PTR_OVER        2'h3

// ****************************************************************
// Configuration field positions and reset values
// ****************************************************************
`define TSA_CFG_SHUTDOWN    0
`define TSA_CFG_INT_MODE    1
`define TSA_CFG_LEVEL_SEL   2
`define TSA_CFG_FQ_LO       3
`define TSA_CFG_FQ_HI       4
`define TSA_CFG_RESET       8'h00
`define TSA_OVER_RESET      16'h5000
`define TSA_HYST_RESET      16'h4B00
`define TSA_ADDR_HI_RESET   4'h9

// ****************************************************************
// Result layout and link timing
// ****************************************************************
`define TSA_RES_MSB         15
`define TSA_RES_LSB         7
`define TSA_RES_PAD         7'h00
`define TSA_SCL_MAX_KHZ     400
`define TSA_CORE_MHZ        250
`define TSA_SCL_MIN_CYCLES  ((`TSA_CORE_MHZ * 1000 + `TSA_SCL_MAX_KHZ - 1) / `TSA_SCL_MAX_KHZ)

`endif

// ==== design/tsa_pkg.sv ====
// Purpose: Types of the temperature sensor alarm core
// Assumes: Constants live in tsa_defines.svh
// Notes:   Types only
package tsa_pkg;

    // ************************************************************
    // Serial engine states
    // ************************************************************
    typedef enum logic [3:0] {
        TSA_ST_IDLE  = 4'b0001,
        TSA_ST_ADDR  = 4'b0010,
        TSA_ST_WDATA = 4'b0100,
        TSA_ST_RDATA = 4'b1000
    } tsa_state_t;

    // ************************************************************
    // Write request handed from the link to the core
    // ************************************************************
    typedef struct packed {
        logic [1:0]  ptr;
        logic        has_data;
        logic [15:0] data;
    } tsa_wr_t;

    // ************************************************************
    // Decoded configuration
    // ************************************************************
    typedef struct packed {
        logic [1:0] fault_queue;
        logic       alert_level_select;
        logic       int_mode;
        logic       shutdown;
    } tsa_cfg_t;

endpackage

// ==== design/tsa_core.sv ====
// Purpose: Temperature result, setpoints, fault queue and alert, two-wire slave
// Assumes: Converter hands a 9-bit code with a one-cycle conv_valid on core_clk
// Notes:   Serial engine runs on scl_clk; core state on core_clk
//
// Notes on behaviour
// - Store each conversion as 16-bit result
// - Result MSB is the sign flag
// - Code sits in bits 15..7, rest zero
// - Reads never disturb running conversions
// - Compare each result, then update alert
// - Fault queue needs consecutive qualifying conversions
// - Polarity bit selects alert level, low default
// - Alert only pulls low or releases
// - Comparator and interrupt alarm behaviours
// - Interrupt mode signals over-limit as event
// - Comparator mode holds level with hysteresis
// - Conversions start right after reset
// - Three straps give address low bits
// - Serial clock at most 400 kHz
// - Two 16-bit read/write setpoint registers
// - Setpoints keep every written bit
// - All user registers reachable over serial link
// - Result code is 9 bits, half degree
// - Queue codes give 1, 2, 4, 6
// - Interrupt alert cleared by read or shutdown
// - Comparator asserts above limit, holds until below
`timescale 1ns/1ps
`default_nettype none
`include "tsa_defines.svh"

module tsa_core
    import tsa_pkg::*;
#(
    parameter logic [3:0]  ADDR_HI    = `TSA_ADDR_HI_RESET,
    parameter logic [15:0] OVER_RESET = `TSA_OVER_RESET,
    parameter logic [15:0] HYST_RESET = `TSA_HYST_RESET
)(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_clk,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       addr_strap_bit0,
    input  wire logic       addr_strap_bit1,
    input  wire logic       addr_strap_bit2,
    output logic            alert_out_o,
    output logic            alert_out_oe,
    output logic            conv_enable,
    input  wire logic       conv_valid,
    input  wire logic [8:0] conv_code
);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [2:0] fq_limit(input logic [1:0] code);
        return (code == 2'b11) ? 3'h6 : 3'h1 << code;
    endfunction

    // ************************************************************
    // Core domain registers
    // ************************************************************
    logic [15:0] temp_q;
    logic [15:0] over_q;
    logic [15:0] hyst_q;
    logic [7:0]  cfg_q;
    logic [1:0]  ptr_q;
    logic [15:0] rd_word_q;
    logic        alarm_q;
    logic        seek_hot_q;
    logic [2:0]  fq_cnt_q;
    logic        alert_oe_q;
    logic        conv_en_q;
    logic [2:0]  strap_s1_q;
    logic [2:0]  strap_s2_q;
    logic [2:0]  wr_sync_q;
    logic [2:0]  rd_sync_q;

    // ************************************************************
    // Link domain registers
    // ************************************************************
    tsa_state_t  state_q;
    logic        start_tgl_q;
    logic        start_seen_q;
    logic [3:0]  bit_cnt_q;
    logic [1:0]  byte_idx_q;
    logic [7:0]  shift_q;
    logic [7:0]  hi_byte_q;
    logic        rd_req_tgl_q;
    logic        wr_tgl_q;
    tsa_wr_t     wr_q;
    logic        sda_oe_q;

    // ************************************************************
    // Decode
    // ************************************************************
    tsa_cfg_t    cfg;
    logic        wr_evt;
    logic        rd_evt;
    logic        sd_set;
    logic        hot;
    logic        cold;
    logic        qual;
    logic        trip;
    logic [2:0]  fq_next;
    logic        clr_int;
    logic [15:0] sel_word;
    logic [6:0]  own_addr;
    logic [7:0]  addr_byte;
    logic        addr_hit;
    logic        new_frame;
    logic        rd_bit;

    assign cfg = tsa_cfg_t'({cfg_q[`TSA_CFG_FQ_HI:`TSA_CFG_FQ_LO], cfg_q[`TSA_CFG_LEVEL_SEL],
                             cfg_q[`TSA_CFG_INT_MODE], cfg_q[`TSA_CFG_SHUTDOWN]});
    assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
    assign rd_evt = rd_sync_q[2] ^ rd_sync_q[1];
    assign sd_set = wr_evt && wr_q.has_data && (wr_q.ptr == `TSA_PTR_CONFIG)
                    && wr_q.data[8 + `TSA_CFG_SHUTDOWN] && !cfg.shutdown;
    // Whole 9-bit fields compared signed, once per result
    assign hot = $signed(conv_code) > $signed(over_q[`TSA_RES_MSB:`TSA_RES_LSB]);
    assign cold = $signed(conv_code) < $signed(hyst_q[`TSA_RES_MSB:`TSA_RES_LSB]);
    assign qual = seek_hot_q ? hot : cold;
    assign fq_next = fq_cnt_q + 3'h1;
    assign trip = conv_valid && qual && (fq_next >= fq_limit(cfg.fault_queue));
    assign clr_int = cfg.int_mode && (rd_evt || sd_set);
    assign sel_word = (ptr_q == `TSA_PTR_TEMP)   ? temp_q :
                      (ptr_q == `TSA_PTR_CONFIG) ? {cfg_q, 8'h00} :
                      (ptr_q == `TSA_PTR_HYST)   ? hyst_q : over_q;

    // ************************************************************
    // Pin synchronisers and crossings
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
            wr_sync_q  <= 3'h0;
            rd_sync_q  <= 3'h0;
        end
        else
        begin
            strap_s1_q <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_s2_q <= strap_s1_q;
            wr_sync_q  <= {wr_sync_q[1:0], wr_tgl_q};
            rd_sync_q  <= {rd_sync_q[1:0], rd_req_tgl_q};
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            temp_q    <= 16'h0000;
            over_q    <= OVER_RESET;
            hyst_q    <= HYST_RESET;
            cfg_q     <= `TSA_CFG_RESET;
            ptr_q     <= `TSA_PTR_TEMP;
            rd_word_q <= 16'h0000;
        end
        else
        begin
            if (conv_valid)
            begin
                temp_q <= {conv_code, `TSA_RES_PAD};
            end
            if (wr_evt)
            begin
                ptr_q <= wr_q.ptr;
                if (wr_q.has_data && wr_q.ptr == `TSA_PTR_CONFIG)
                begin
                    cfg_q <= wr_q.data[15:8];
                end
                if (wr_q.has_data && wr_q.ptr == `TSA_PTR_OVER)
                begin
                    over_q <= wr_q.data;
                end
                if (wr_q.has_data && wr_q.ptr == `TSA_PTR_HYST)
                begin
                    hyst_q <= wr_q.data;
                end
            end
            // Snapshot taken on request only, so conversions run on
            if (rd_evt)
            begin
                rd_word_q <= sel_word;
            end
        end
    end

    // ************************************************************
    // Fault queue and alarm
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_q    <= 1'b0;
            seek_hot_q <= 1'b1;
            fq_cnt_q   <= 3'h0;
            alert_oe_q <= 1'b0;
            conv_en_q  <= 1'b0;
        end
        else
        begin
            conv_en_q <= !cfg.shutdown;
            if (conv_valid)
            begin
                fq_cnt_q <= (qual && !trip) ? fq_next : 3'h0;
            end
            if (trip)
            begin
                seek_hot_q <= !seek_hot_q;
                // A trip in the same cycle as a clear wins
                alarm_q <= cfg.int_mode ? 1'b1 : seek_hot_q;
            end
            else if (clr_int)
            begin
                alarm_q <= 1'b0;
            end
            // Pull low when the alarm is set with low level selected, or clear with high level selected
            alert_oe_q <= alarm_q ^ cfg.alert_level_select;
        end
    end

    assign alert_out_o  = 1'b0;
    assign alert_out_oe = alert_oe_q;
    assign conv_enable  = conv_en_q;

    // ************************************************************
    // Start detection on the data line
    // ************************************************************
    // A start is the only framing the engine needs; a stop just idles
    always_ff @(negedge sda_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_tgl_q <= 1'b0;
        end
        else if (scl_clk)
        begin
            start_tgl_q <= !start_tgl_q;
        end
    end

    // ************************************************************
    // Serial engine, sampling edge
    // ************************************************************
    assign own_addr  = {ADDR_HI, strap_s2_q};
    assign addr_byte = {shift_q[6:0], sda_i};
    assign addr_hit  = addr_byte[7:1] == own_addr;
    assign new_frame = start_tgl_q != start_seen_q;

    always_ff @(posedge scl_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q      <= TSA_ST_IDLE;
            start_seen_q <= 1'b0;
            bit_cnt_q    <= 4'h0;
            byte_idx_q   <= 2'h0;
            shift_q      <= 8'h00;
            hi_byte_q    <= 8'h00;
            rd_req_tgl_q <= 1'b0;
            wr_tgl_q     <= 1'b0;
            wr_q         <= '0;
        end
        else if (new_frame)
        begin
            start_seen_q <= start_tgl_q;
            state_q      <= TSA_ST_ADDR;
            shift_q      <= {7'h00, sda_i};
            bit_cnt_q    <= 4'h1;
            byte_idx_q   <= 2'h0;
        end
        else
        begin
            unique case (state_q)
                TSA_ST_IDLE:  bit_cnt_q <= 4'h0;
                TSA_ST_ADDR:
                begin
                    if (bit_cnt_q != 4'h8)
                    begin
                        shift_q   <= addr_byte;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7 && addr_hit && sda_i)
                        begin
                            // Core has one and a half link clocks to capture the word
                            rd_req_tgl_q <= !rd_req_tgl_q;
                        end
                    end
                    else
                    begin
                        bit_cnt_q <= 4'h0;
                        if (shift_q[7:1] != own_addr)
                        begin
                            state_q <= TSA_ST_IDLE;
                        end
                        else
                        begin
                            state_q <= shift_q[0] ? TSA_ST_RDATA : TSA_ST_WDATA;
                        end
                    end
                end
                TSA_ST_WDATA:
                begin
                    if (bit_cnt_q != 4'h8)
                    begin
                        shift_q   <= addr_byte;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7)
                        begin
                            if (byte_idx_q == 2'h0)
                            begin
                                wr_q     <= '{ptr: addr_byte[1:0], has_data: 1'b0,
                                              data: 16'h0000};
                                wr_tgl_q <= !wr_tgl_q;
                            end
                            else if (byte_idx_q == 2'h1)
                            begin
                                hi_byte_q <= addr_byte;
                                if (wr_q.ptr == `TSA_PTR_CONFIG)
                                begin
                                    wr_q.has_data <= 1'b1;
                                    wr_q.data     <= {addr_byte, 8'h00};
                                    wr_tgl_q      <= !wr_tgl_q;
                                end
                            end
                            else if (byte_idx_q == 2'h2 && wr_q.ptr[1])
                            begin
                                wr_q.has_data <= 1'b1;
                                wr_q.data     <= {hi_byte_q, addr_byte};
                                wr_tgl_q      <= !wr_tgl_q;
                            end
                        end
                    end
                    else
                    begin
                        bit_cnt_q <= 4'h0;
                        if (byte_idx_q != 2'h3)
                        begin
                            byte_idx_q <= byte_idx_q + 2'h1;
                        end
                    end
                end
                TSA_ST_RDATA:
                begin
                    if (bit_cnt_q != 4'h8)
                    begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    else
                    begin
                        bit_cnt_q  <= 4'h0;
                        byte_idx_q <= {1'b0, !byte_idx_q[0]};
                        state_q    <= sda_i ? TSA_ST_IDLE : TSA_ST_RDATA;
                    end
                end
                default:      state_q <= TSA_ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Serial engine, driving edge
    // ************************************************************
    // High byte first; config reads give its byte then zero
    assign rd_bit = rd_word_q[{!byte_idx_q[0], 3'h7} - bit_cnt_q];

    always_ff @(negedge scl_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_oe_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                TSA_ST_ADDR:  sda_oe_q <= (bit_cnt_q == 4'h8) && (shift_q[7:1] == own_addr);
                TSA_ST_WDATA: sda_oe_q <= (bit_cnt_q == 4'h8);
                TSA_ST_RDATA: sda_oe_q <= (bit_cnt_q != 4'h8) && !rd_bit;
                default:      sda_oe_q <= 1'b0;
            endcase
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_q;

endmodule

`default_nettype wire

// ==== bench/tsa_props.sv ====
// Purpose: Port assertions for tsa_core
// Assumes: Latencies as handed over by the designer
// Notes:   Bound to every tsa_core instance
`timescale 1ns/1ps
`default_nettype none
module tsa_props
    import tsa_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       scl_clk,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       addr_strap_bit0,
    input wire logic       addr_strap_bit1,
    input wire logic       addr_strap_bit2,
    input wire logic       alert_out_o,
    input wire logic       alert_out_oe,
    input wire logic       conv_enable,
    input wire logic       conv_valid,
    input wire logic [8:0] conv_code
);
    // ********
    // Age of the last conversion and link edge
    // ********
    logic [3:0] conv_age_q;
    logic [3:0] conv_age_d;
    logic [3:0] link_age_q;
    logic [3:0] link_age_d;
    logic       scl_last_q;
    // Saturate so a long quiet spell never wraps into a false cause
    assign conv_age_d = conv_valid ? 4'h0 : conv_age_q + {3'h0, conv_age_q != 4'hF};
    assign link_age_d = (scl_clk != scl_last_q) ? 4'h0 : link_age_q + {3'h0, link_age_q != 4'hF};
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_age_q <= 4'hF;
            link_age_q <= 4'hF;
            scl_last_q <= 1'b1;
        end
        else
        begin
            conv_age_q <= conv_age_d;
            link_age_q <= link_age_d;
            scl_last_q <= scl_clk;
        end
    end
    // ********
    // Assertions
    // ********
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_conv_after_reset: assert property ($rose(rst_n) |=> conv_enable)
        else $error("converter not enabled after reset");
    a_pins_free_reset: assert property ($rose(rst_n) |-> !alert_out_oe && !sda_oe)
        else $error("pin pulled low at reset release");
    a_alert_never_high: assert property (alert_out_o == 1'b0)
        else $error("alert pin driven high");
    a_sda_never_high: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_alert_conv_delay: assert property (($changed(alert_out_oe) && link_age_q == 4'hF)
        |-> conv_age_q == 4'h1) else $error("alert moved at wrong delay after conversion");
    a_alert_has_cause: assert property ($changed(alert_out_oe)
        |-> conv_age_q == 4'h1 || link_age_q < 4'h8) else $error("alert moved without cause");
    a_sda_holds_high: assert property ((scl_clk && $past(scl_clk)) |-> $stable(sda_oe))
        else $error("data changed while link clock high");
    a_conv_stop_link: assert property ($fell(conv_enable) |-> link_age_q < 4'h8)
        else $error("conversion stopped without link write");
endmodule
bind tsa_core tsa_props props_u (
    .core_clk, .rst_n, .scl_clk, .sda_i, .sda_o, .sda_oe,
    .addr_strap_bit0, .addr_strap_bit1, .addr_strap_bit2,
    .alert_out_o, .alert_out_oe, .conv_enable, .conv_valid, .conv_code
);
`default_nettype wire

// ==== bench/tsa_i2c_master.sv ====
// Purpose: Two-wire bus master model
// Assumes: Data line pulled up by the bench
// Notes:   Link clock stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module tsa_i2c_master
    import tsa_pkg::*;
(
    output var logic  scl,
    output var logic  sda_pull,
    input  wire logic sda_line
);
    // Far faster than a real bus to keep runs short; still nearly four core cycles per phase
    localparam int HALF = 15;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic put_bit(input logic b);
        #2 sda_pull = ~b;
        #(HALF - 2) scl = 1'b1;
        #HALF scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        #2 sda_pull = 1'b0;
        #(HALF - 2) scl = 1'b1;
        b = sda_line;
        #HALF scl = 1'b0;
    endtask
    task automatic start();
        if (!scl)
        begin
            #2 sda_pull = 1'b0;
            #(HALF - 2) scl = 1'b1;
        end
        #HALF sda_pull = 1'b1;
        #HALF scl = 1'b0;
    endtask
    task automatic stop();
        #2 sda_pull = 1'b1;
        #(HALF - 2) scl = 1'b1;
        #HALF sda_pull = 1'b0;
        #HALF;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ok);
        logic a;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i]);
        get_bit(a);
        ok = (a === 1'b0);
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            get_bit(b[i]);
        put_bit(last);
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [1:0] ptr,
                             input logic [15:0] d, input int nb, output logic ok);
        logic a;
        start();
        send_byte({dev, 1'b0}, ok);
        if (ok)
        begin
            send_byte({6'h00, ptr}, a);
            ok = ok & a;
            for (int i = 0; i < nb; i++)
            begin
                send_byte((i == 0) ? d[15:8] : d[7:0], a);
                ok = ok & a;
            end
        end
        stop();
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [1:0] ptr,
                            output logic [15:0] d, output logic ok);
        logic a;
        start();
        send_byte({dev, 1'b0}, ok);
        send_byte({6'h00, ptr}, a);
        ok = ok & a;
        start();
        send_byte({dev, 1'b1}, a);
        ok = ok & a;
        recv_byte(1'b0, d[15:8]);
        recv_byte(1'b1, d[7:0]);
        stop();
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for tsa_core
// Assumes: Master model drives the link
// Notes:   Data and alert lines pulled up here
`timescale 1ns/1ps
`default_nettype none
`include "tsa_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import tsa_pkg::*;
    localparam logic [6:0] DEV = {`TSA_ADDR_HI_RESET, 3'h5};
    logic        core_clk, rst_n, conv_valid, scl, m_pull, ack;
    logic        sda_o, sda_oe, alert_o, alert_oe, conv_en;
    logic [2:0]  straps;
    logic [8:0]  conv_code;
    logic [15:0] rd;
    logic [8:0]  codes [7] = '{9'h0FA, 9'h032, 9'h001, 9'h000, 9'h1FF, 9'h1CE, 9'h192};
    int          num_errors, compares, n;
    wire         sda_line, alert_pin;
    assign sda_line = ~(m_pull | (sda_oe & ~sda_o));
    assign alert_pin = ~(alert_oe & ~alert_o);
    tsa_core dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit0(straps[0]),
        .addr_strap_bit1(straps[1]), .addr_strap_bit2(straps[2]),
        .alert_out_o(alert_o), .alert_out_oe(alert_oe), .conv_enable(conv_en),
        .conv_valid(conv_valid), .conv_code(conv_code)
    );
    tsa_i2c_master master_u (.scl(scl), .sda_pull(m_pull), .sda_line(sda_line));
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ********
    // Access tasks
    // ********
    task automatic final_report();
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic wr(input logic [1:0] p, input logic [15:0] d, input int nb);
        master_u.write_reg(DEV, p, d, nb, ack);
        `CHK(ack, 1'b1)
        repeat (4) @(posedge core_clk);
    endtask
    task automatic rd_chk(input logic [1:0] p, input logic [15:0] e);
        master_u.read_reg(DEV, p, rd, ack);
        `CHK({ack, rd}, {1'b1, e})
    endtask
    // Quiet gap first so the alert delay is seen apart from link traffic
    task automatic conv(input logic [8:0] c);
        repeat (12) @(posedge core_clk);
        conv_valid <= 1'b1;
        conv_code <= c;
        @(posedge core_clk);
        conv_valid <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic pin(input logic e);
        `CHK(alert_pin, e)
    endtask
    initial
    begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
    // ********
    // Scenarios
    // ********
    initial
    begin
        rst_n = 1'b0;
        straps = 3'h5;
        conv_valid = 1'b0;
        conv_code = 9'h000;
        num_errors = 0;
        compares = 0;
        do_reset();
        `CHK(conv_en, 1'b1)
        pin(1'b1);
        rd_chk(`TSA_PTR_OVER, `TSA_OVER_RESET);
        rd_chk(`TSA_PTR_HYST, `TSA_HYST_RESET);
        wr(`TSA_PTR_OVER, 16'h1234, 2);
        wr(`TSA_PTR_HYST, 16'hABCD, 2);
        wr(`TSA_PTR_OVER, 16'h5555, 1);
        rd_chk(`TSA_PTR_OVER, 16'h1234);
        rd_chk(`TSA_PTR_HYST, 16'hABCD);
        for (int s = 0; s < 8; s++)
        begin
            @(posedge core_clk);
            straps <= s[2:0];
            repeat (4) @(posedge core_clk);
            master_u.write_reg({`TSA_ADDR_HI_RESET, s[2:0]}, `TSA_PTR_CONFIG, 16'h0000, 1, ack);
            `CHK(ack, 1'b1)
            master_u.write_reg({`TSA_ADDR_HI_RESET, s[2:0] ^ 3'h1}, `TSA_PTR_CONFIG, 16'h0000, 1, ack);
            `CHK(ack, 1'b0)
        end
        @(posedge core_clk);
        straps <= 3'h5;
        repeat (4) @(posedge core_clk);
        foreach (codes[i])
        begin
            conv(codes[i]);
            rd_chk(`TSA_PTR_TEMP, {codes[i], 7'h00});
            `CHK(rd[15], codes[i][8])
        end
        fork
            master_u.read_reg(DEV, `TSA_PTR_TEMP, rd, ack);
            conv(9'h064);
        join
        rd_chk(`TSA_PTR_TEMP, {9'h064, 7'h00});
        wr(`TSA_PTR_OVER, 16'h507F, 2);
        wr(`TSA_PTR_HYST, 16'h4B7F, 2);
        conv(9'h095);
        for (int q = 0; q < 4; q++)
        begin
            n = (q == 0) ? 1 : (q == 1) ? 2 : (q == 2) ? 4 : 6;
            wr(`TSA_PTR_CONFIG, {3'h0, q[1:0], 3'h0, 8'h00}, 1);
            repeat (n - 1) conv(9'h0A1);
            conv(9'h0A0);
            repeat (n - 1) conv(9'h0A1);
            pin(1'b1);
            conv(9'h0A1);
            pin(1'b0);
            repeat (n - 1) conv(9'h095);
            pin(1'b0);
            conv(9'h095);
            pin(1'b1);
        end
        wr(`TSA_PTR_CONFIG, 16'h0000, 1);
        conv(9'h0A1);
        pin(1'b0);
        wr(`TSA_PTR_CONFIG, 16'h0400, 1);
        pin(1'b1);
        conv(9'h095);
        pin(1'b0);
        wr(`TSA_PTR_CONFIG, 16'h0000, 1);
        wr(`TSA_PTR_OVER, 16'hE700, 2);
        wr(`TSA_PTR_HYST, 16'hE600, 2);
        conv(9'h000);
        pin(1'b0);
        conv(9'h1C0);
        pin(1'b1);
        do_reset();
        `CHK(conv_en, 1'b1)
        wr(`TSA_PTR_CONFIG, 16'h0200, 1);
        conv(9'h0A1);
        pin(1'b0);
        conv(9'h0A1);
        pin(1'b0);
        rd_chk(`TSA_PTR_TEMP, {9'h0A1, 7'h00});
        pin(1'b1);
        conv(9'h0A1);
        pin(1'b1);
        conv(9'h095);
        pin(1'b0);
        wr(`TSA_PTR_CONFIG, 16'h0300, 1);
        pin(1'b1);
        `CHK(conv_en, 1'b0)
        rd_chk(`TSA_PTR_CONFIG, 16'h0300);
        rd_chk(`TSA_PTR_TEMP, {9'h095, 7'h00});
        final_report();
    end
endmodule
`default_nettype wire
